// file: common/lcc_pkg.sv
// Package for the lithium charge state controller: states, levels and timing.
// Assumes a 20 MHz free-running clock; timer figures are in minutes or tenths of a minute at the nominal capacitor.
package lcc_pkg;

  // Clock rate.
  localparam longint unsigned CLK_HZ = 64'd20_000_000;

  // Nominal state timer durations at the reference timing capacitor.
  localparam longint unsigned PREQ_TIME_MIN = 64'd348;  // Tenths of a minute: 34.8 min.
  localparam longint unsigned CHG_TIME_MIN  = 64'd334;  // Whole minutes.
  localparam longint unsigned TOP_TIME_MIN  = 64'd348;  // Tenths of a minute: 34.8 min.

  // Cycle counts derived from the durations, rounded down as longest times.
  localparam longint unsigned PREQ_CYCLES = (PREQ_TIME_MIN * 64'd60 * CLK_HZ) / 64'd10;
  localparam longint unsigned CHG_CYCLES  = CHG_TIME_MIN * 64'd60 * CLK_HZ;
  localparam longint unsigned TOP_CYCLES  = (TOP_TIME_MIN * 64'd60 * CLK_HZ) / 64'd10;

  // Width of the state timer counter.
  localparam int TMR_W = 40;

  // Capacitor scale: 128 means the reference capacitor (68 nF).
  localparam int          SCALE_W   = 8;
  localparam logic [7:0]  SCALE_REF = 8'h80;
  localparam int          SCALE_SH  = 7;

  // Charge current request levels, relative units.
  localparam int          LVL_W     = 4;
  localparam logic [3:0]  LVL_OFF   = 4'h0;
  localparam logic [3:0]  LVL_PREQ  = 4'h1;
  localparam logic [3:0]  LVL_FULL  = 4'hA;  // Ten times the pre-charge level.
  localparam logic [3:0]  LVL_CV    = 4'hF;  // Voltage regulation with top-off current.

  // Controller states, Gray coded along disabled, pre-charge, charge, top-off, done.
  typedef enum logic [2:0] {
    LCC_DIS  = 3'h0,
    LCC_PREQ = 3'h1,
    LCC_CHG  = 3'h3,
    LCC_TOP  = 3'h2,
    LCC_DONE = 3'h6,
    LCC_HOLD = 3'h7,
    LCC_FAULT = 3'h5
  } lcc_state_t;

endpackage : lcc_pkg

// file: rtl/lcc_timer.sv
// State timer: counts while running, holds while frozen, flags when the limit is reached.
// Assumes the limit is stable for the duration of a count.
`timescale 1ns/1ns
`default_nettype none
module lcc_timer #(
  parameter int W = 40
) (
  // Clock and reset
  input  wire logic         mclk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         clear_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] limit_i,
  // Status
  output logic              expired_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic         exp_r;
  logic         exp_nxt;

  always_comb begin
    cnt_nxt = cnt_r;
    exp_nxt = exp_r;
    if (clear_i) begin
      cnt_nxt = '0;
      exp_nxt = 1'b0;
    end else if (run_i && !exp_r) begin
      if (cnt_r >= limit_i - 1'b1) begin
        exp_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= '0;
      exp_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign expired_o = exp_r;

endmodule : lcc_timer
`default_nettype wire

// file: rtl/lcc_ctrl.sv
// Lithium charge state controller: sequences disabled, pre-charge, charge, top-off,
// done, fault and temperature hold from comparator decisions.
// Assumes all comparator inputs are synchronous to mclk_i and already filtered.
`timescale 1ns/1ns
`default_nettype none
module lcc_ctrl #(
  parameter longint unsigned PREQ_CYC = lcc_pkg::PREQ_CYCLES,
  parameter longint unsigned CHG_CYC  = lcc_pkg::CHG_CYCLES,
  parameter longint unsigned TOP_CYC  = lcc_pkg::TOP_CYCLES
) (
  // Clock and reset
  input  wire logic                        mclk_i,
  input  wire logic                        rst_n_i,
  // Comparator decisions
  input  wire logic                        supply_valid_i,
  input  wire logic                        enable_i,
  input  wire logic                        bat_ge_3v_i,
  input  wire logic                        bat_lt_4v05_i,
  input  wire logic                        taper_reached_i,
  input  wire logic                        thermistor_sense_ok_i,
  // Timer scale from the timing capacitor, SCALE_REF is nominal
  input  wire logic [lcc_pkg::SCALE_W-1:0] timer_capacitor_pin_i,
  // Charge request and flags
  output logic [lcc_pkg::LVL_W-1:0]        current_level_o,
  output logic                             volt_regulate_o,
  output logic                             power_ok_o,
  output logic                             charging_flag_o,
  output logic                             battery_fault_flag_o,
  output logic                             temp_hold_o,
  output logic                             done_o,
  output logic [2:0]                       state_o
);

  localparam int TW = lcc_pkg::TMR_W;

  lcc_pkg::lcc_state_t state_r, state_nxt;
  lcc_pkg::lcc_state_t resume_r, resume_nxt;
  logic [lcc_pkg::LVL_W-1:0] lvl_r, lvl_nxt;
  logic cv_r, cv_nxt;
  logic pok_r, pok_nxt;
  logic chg_r, chg_nxt;
  logic fault_r, fault_nxt;
  logic hold_r, hold_nxt;
  logic done_r, done_nxt;

  logic          tmr_clear;
  logic          tmr_run;
  logic          tmr_exp;
  logic [TW-1:0] base_lim;
  logic [TW-1:0] tmr_lim;
  logic [TW+lcc_pkg::SCALE_W-1:0] scaled;
  logic          active;

  assign active = supply_valid_i && enable_i;

  // Timer length follows the capacitor linearly.
  always_comb begin
    base_lim = TW'(CHG_CYC);
    if (state_r == lcc_pkg::LCC_PREQ ||
        (state_r == lcc_pkg::LCC_HOLD && resume_r == lcc_pkg::LCC_PREQ)) begin
      base_lim = TW'(PREQ_CYC);
    end else if (state_r == lcc_pkg::LCC_TOP) begin
      base_lim = TW'(TOP_CYC);
    end
    scaled  = (base_lim * timer_capacitor_pin_i) >> lcc_pkg::SCALE_SH;
    tmr_lim = (scaled[TW+lcc_pkg::SCALE_W-1:TW] != '0) ? '1 : scaled[TW-1:0];
    if (tmr_lim == '0) begin
      tmr_lim = TW'(1);
    end
  end

  // Timer restarts on each state change except into and out of hold.
  always_comb begin
    tmr_clear = (state_nxt != state_r) &&
                (state_nxt != lcc_pkg::LCC_HOLD) &&
                (state_r != lcc_pkg::LCC_HOLD);
    tmr_run   = (state_r == lcc_pkg::LCC_PREQ) ||
                (state_r == lcc_pkg::LCC_CHG) ||
                (state_r == lcc_pkg::LCC_TOP);
  end

  lcc_timer #(
    .W         (TW)
  ) u_timer (
    .mclk_i    (mclk_i),
    .rst_n_i   (rst_n_i),
    .clear_i   (tmr_clear),
    .run_i     (tmr_run),
    .limit_i   (tmr_lim),
    .expired_o (tmr_exp)
  );

  // State sequencing.
  always_comb begin
    state_nxt  = state_r;
    resume_nxt = resume_r;
    if (!active) begin
      state_nxt = lcc_pkg::LCC_DIS;
    end else begin
      unique case (state_r)
        lcc_pkg::LCC_DIS: begin
          state_nxt = lcc_pkg::LCC_PREQ;
        end
        lcc_pkg::LCC_PREQ: begin
          if (!thermistor_sense_ok_i) begin
            state_nxt  = lcc_pkg::LCC_HOLD;
            resume_nxt = lcc_pkg::LCC_PREQ;
          end else if (bat_ge_3v_i) begin
            state_nxt = lcc_pkg::LCC_CHG;
          end else if (tmr_exp) begin
            state_nxt = lcc_pkg::LCC_FAULT;
          end
        end
        lcc_pkg::LCC_CHG: begin
          if (!thermistor_sense_ok_i) begin
            state_nxt  = lcc_pkg::LCC_HOLD;
            resume_nxt = lcc_pkg::LCC_CHG;
          end else if (taper_reached_i) begin
            state_nxt = lcc_pkg::LCC_TOP;
          end else if (tmr_exp) begin
            state_nxt = lcc_pkg::LCC_FAULT;
          end
        end
        lcc_pkg::LCC_TOP: begin
          if (tmr_exp) begin
            state_nxt = lcc_pkg::LCC_DONE;
          end
        end
        lcc_pkg::LCC_DONE: begin
          if (bat_lt_4v05_i) begin
            state_nxt = lcc_pkg::LCC_CHG;
          end
        end
        lcc_pkg::LCC_HOLD: begin
          if (thermistor_sense_ok_i) begin
            state_nxt = resume_r;
          end
        end
        lcc_pkg::LCC_FAULT: begin
          state_nxt = lcc_pkg::LCC_FAULT;
        end
        default: begin
          state_nxt = lcc_pkg::LCC_DIS;
        end
      endcase
    end
  end

  // Registered outputs from the next state; power good is registered from supply_valid_i.
  always_comb begin
    lvl_nxt  = lcc_pkg::LVL_OFF;
    cv_nxt   = 1'b0;
    pok_nxt  = supply_valid_i;
    chg_nxt  = chg_r;
    fault_nxt = (state_nxt == lcc_pkg::LCC_FAULT);
    hold_nxt = (state_nxt == lcc_pkg::LCC_HOLD);
    done_nxt = (state_nxt == lcc_pkg::LCC_DONE);
    unique case (state_nxt)
      lcc_pkg::LCC_PREQ: begin
        lvl_nxt = lcc_pkg::LVL_PREQ;
        chg_nxt = 1'b0;
      end
      lcc_pkg::LCC_CHG: begin
        lvl_nxt = lcc_pkg::LVL_FULL;
        chg_nxt = 1'b1;
      end
      lcc_pkg::LCC_TOP: begin
        lvl_nxt = lcc_pkg::LVL_CV;
        cv_nxt  = 1'b1;
        chg_nxt = 1'b0;
      end
      lcc_pkg::LCC_HOLD: begin
        lvl_nxt = lcc_pkg::LVL_OFF;
      end
      default: begin
        lvl_nxt = lcc_pkg::LVL_OFF;
        chg_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r  <= lcc_pkg::LCC_DIS;
      resume_r <= lcc_pkg::LCC_PREQ;
      lvl_r    <= lcc_pkg::LVL_OFF;
      cv_r     <= 1'b0;
      pok_r    <= 1'b0;
      chg_r    <= 1'b0;
      fault_r  <= 1'b0;
      hold_r   <= 1'b0;
      done_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      resume_r <= resume_nxt;
      lvl_r    <= lvl_nxt;
      cv_r     <= cv_nxt;
      pok_r    <= pok_nxt;
      chg_r    <= chg_nxt;
      fault_r  <= fault_nxt;
      hold_r   <= hold_nxt;
      done_r   <= done_nxt;
    end
  end

  assign current_level_o      = lvl_r;
  assign volt_regulate_o      = cv_r;
  assign power_ok_o           = pok_r;
  assign charging_flag_o      = chg_r;
  assign battery_fault_flag_o = fault_r;
  assign temp_hold_o          = hold_r;
  assign done_o               = done_r;
  assign state_o              = state_r;

endmodule : lcc_ctrl
`default_nettype wire

// file: sim/lcc_ctrl_properties.sv
// Checker for the charge state controller, seeing its top-level ports only.
// Assumes it is bound to lcc_ctrl and that state codes follow the package.
`timescale 1ns/1ns
`default_nettype none
module lcc_ctrl_properties (
  input wire logic       mclk_i,
  input wire logic       rst_n_i,
  input wire logic       supply_valid_i,
  input wire logic       enable_i,
  input wire logic       bat_ge_3v_i,
  input wire logic       bat_lt_4v05_i,
  input wire logic       taper_reached_i,
  input wire logic       thermistor_sense_ok_i,
  input wire logic [3:0] current_level_o,
  input wire logic       volt_regulate_o,
  input wire logic       battery_fault_flag_o,
  input wire logic       done_o,
  input wire logic [2:0] state_o
);
  logic on;
  logic ok;
  assign on = supply_valid_i && enable_i;
  assign ok = on && thermistor_sense_ok_i;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  AST_OFF: assert property (!on |=> state_o == 3'h0 && current_level_o == 4'h0)
    else $error("Not disabled after supply or enable loss");
  AST_START: assert property (on && state_o == 3'h0 |=> state_o == 3'h1 && current_level_o == 4'h1)
    else $error("Pre-charge not entered");
  AST_PRE_GO: assert property (ok && state_o == 3'h1 && bat_ge_3v_i |=> state_o == 3'h3)
    else $error("Charge not entered at 3V");
  AST_PRE_HOT: assert property (on && !thermistor_sense_ok_i && state_o == 3'h1 |=> state_o == 3'h7)
    else $error("Pre-charge not suspended");
  AST_CHG_HOT: assert property (on && !thermistor_sense_ok_i && state_o == 3'h3 |=> state_o == 3'h7)
    else $error("Charge not suspended");
  AST_FULL: assert property (state_o == 3'h3 |-> current_level_o == 4'hA)
    else $error("Charge level wrong");
  AST_TAPER: assert property (ok && state_o == 3'h3 && taper_reached_i |=> state_o == 3'h2 && volt_regulate_o)
    else $error("Top-off not entered on taper");
  AST_DONE: assert property (state_o == 3'h6 |-> current_level_o == 4'h0 && done_o)
    else $error("Done state draws current");
  AST_RECHG: assert property (on && state_o == 3'h6 && bat_lt_4v05_i |=> state_o == 3'h3)
    else $error("No recharge below 4.05V");
  AST_LATCH: assert property (on && state_o == 3'h5 |=> state_o == 3'h5 && battery_fault_flag_o)
    else $error("Fault did not stay latched");
  AST_TOPOFF: assert property (state_o == 3'h2 |-> current_level_o == 4'hF && volt_regulate_o)
    else $error("Top-off level or regulation wrong");
  AST_RESUME: assert property (on && state_o == 3'h7 && thermistor_sense_ok_i |=> (state_o == 3'h1 || state_o == 3'h3))
    else $error("Hold not left on valid temperature");
endmodule : lcc_ctrl_properties
`default_nettype wire

// file: sim/lcc_cell_model.sv
// Behavioural cell with thermistor: voltage climbs with the requested current.
// Assumes the bench may preset mv and drives hot_i to force a temperature trip.
`timescale 1ns/1ns
`default_nettype none
module lcc_cell_model (
  input  wire logic       mclk_i,
  input  wire logic [3:0] level_i,
  input  wire logic       hot_i,
  output logic            bat_ge_3v_o,
  output logic            bat_lt_4v05_o,
  output logic            taper_o,
  output logic            therm_ok_o
);
  int mv = 3700;
  always @(posedge mclk_i) begin
    if (level_i != 4'h0 && mv < 4200) begin
      mv <= mv + 4 * int'(level_i);
    end
  end
  assign bat_ge_3v_o   = mv >= 3000;
  assign bat_lt_4v05_o = mv < 4050;
  assign taper_o       = mv >= 4150;
  assign therm_ok_o    = !hot_i;
endmodule : lcc_cell_model
`default_nettype wire

// file: sim/tb_lcc_ctrl.sv
// Self-checking bench for the charge controller with a cell model at its far side.
// Assumes short timer parameters so that every state sequence ends quickly.
`timescale 1ns/1ns
`default_nettype none
module tb_lcc_ctrl;
  logic       mclk_i = 1'b0;
  logic       rst_n_i = 1'b0;
  logic       sv = 1'b0;
  logic       en = 1'b0;
  logic       hot = 1'b0;
  logic [7:0] cap = 8'h80;
  logic       ge3, lt405, taper, tok, cv, fault, hold, done, chgf, pok;
  logic [3:0] level;
  logic [2:0] state_o;
  int         miscompares = 0;
  int         n_checks = 0;
  lcc_ctrl #(.PREQ_CYC(20), .CHG_CYC(50), .TOP_CYC(20)) DUT (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .supply_valid_i(sv), .enable_i(en),
    .bat_ge_3v_i(ge3), .bat_lt_4v05_i(lt405), .taper_reached_i(taper),
    .thermistor_sense_ok_i(tok), .timer_capacitor_pin_i(cap), .current_level_o(level),
    .volt_regulate_o(cv), .power_ok_o(pok), .charging_flag_o(chgf),
    .battery_fault_flag_o(fault), .temp_hold_o(hold), .done_o(done), .state_o(state_o));
  lcc_cell_model u_cell (.mclk_i(mclk_i), .level_i(level), .hot_i(hot), .bat_ge_3v_o(ge3),
    .bat_lt_4v05_o(lt405), .taper_o(taper), .therm_ok_o(tok));
  initial begin
    forever #25 mclk_i = !mclk_i;
  end
  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : step
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_st(input logic [2:0] s, input int lo, input int hi);
    int n;
    n = 0;
    while (state_o !== s && n < hi) begin
      step(1);
      n++;
    end
    chk(4'(state_o), 4'(s));
    chk(4'(n >= lo), 4'h1);
  endtask : wait_st
  task automatic restart(input int mv);
    en = 1'b0;
    step(1);
    u_cell.mv = mv;
    en = 1'b1;
    step(1);
  endtask : restart
  task automatic t_full();
    chk(4'(state_o), 4'h0);
    u_cell.mv = 2990;
    en = 1'b1;
    step(1);
    chk(level, 4'h1);
    chk({3'h0, pok}, 4'h1);
    wait_st(3'h3, 2, 5);
    chk(level, 4'hA);
    hot = 1'b1;
    step(2);
    chk(4'(state_o), 4'h7);
    chk(4'(chgf), 4'h1);
    hot = 1'b0;
    wait_st(3'h3, 0, 2);
    wait_st(3'h2, 20, 40);
    chk(level, 4'hF);
    chk({3'h0, cv}, 4'h1);
    wait_st(3'h6, 19, 22);
    chk(level, 4'h0);
    chk({3'h0, done}, 4'h1);
    u_cell.mv = 4000;
    wait_st(3'h3, 1, 2);
  endtask : t_full
  task automatic t_fault();
    restart(1000);
    wait_st(3'h5, 18, 22);
    chk(4'(fault), 4'h1);
    step(30);
    chk(4'(state_o), 4'h5);
    sv = 1'b0;
    step(1);
    chk({3'h0, fault}, 4'h0);
    chk({3'h0, pok}, 4'h0);
    sv = 1'b1;
  endtask : t_fault
  task automatic t_hold();
    restart(1000);
    step(7);
    hot = 1'b1;
    step(1);
    chk({hold, state_o}, 4'hF);
    step(40);
    chk(4'(state_o), 4'h7);
    hot = 1'b0;
    step(1);
    chk(4'(state_o), 4'h1);
    wait_st(3'h5, 9, 15);
  endtask : t_hold
  task automatic t_scale();
    cap = 8'h40;
    restart(3010);
    wait_st(3'h3, 0, 2);
    wait_st(3'h5, 22, 27);
  endtask : t_scale
  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  initial begin
    repeat (5) @(posedge mclk_i);
    #2;
    rst_n_i = 1'b1;
    sv = 1'b1;
    t_full();
    t_fault();
    t_hold();
    t_scale();
    finish_test();
  end
  initial begin
    repeat (2000) @(posedge mclk_i);
    miscompares++;
    finish_test();
  end
endmodule : tb_lcc_ctrl
bind lcc_ctrl lcc_ctrl_properties u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .supply_valid_i(supply_valid_i), .enable_i(enable_i), .bat_ge_3v_i(bat_ge_3v_i),
  .bat_lt_4v05_i(bat_lt_4v05_i), .taper_reached_i(taper_reached_i),
  .thermistor_sense_ok_i(thermistor_sense_ok_i), .current_level_o(current_level_o),
  .volt_regulate_o(volt_regulate_o), .battery_fault_flag_o(battery_fault_flag_o),
  .done_o(done_o), .state_o(state_o));
`default_nettype wire
